// ---- anpr_regs.sv ----
// Expansion status and next page exchange registers of one transceiver port.
// Assumes a management frame engine on CLK issuing one-cycle read/write
// strobes, and auto-negotiation arbitration logic on the same clock.
// Function
// - Parallel detection fault latches expansion bit 4
// - Fault bit clears on expansion read, reset
// - Expansion bit 3 mirrors partner ability bit 15
// - Expansion bit 2 always reads one
// - Page received bit latches on new page
// - Page received holds until read or reset
// - Bit 0 shows partner negotiation ability
// - Bit 0 zero before exchange or noncompliant partner
// - Local bit 15 more pages, resets zero
// - Local bit 13 message page, resets one
// - Local bit 12 comply flag, resets zero
// - Local toggle inverts previous sent toggle
// - Toggle alternates on each exchanged page
// - Local code field eleven bits, resets one
// - Partner next page captured, read only, zero
// - Advertisement bit 15 enables next pages
// - Partner ability bit 15 shows partner pages
`default_nettype none
module anpr_regs
	import anpr_pkg::*;
(
	input wire logic CLK,
	input wire logic RSTN,
	input wire logic [4:0] MGMT_ADDR,
	input wire logic MGMT_WR,
	input wire logic MGMT_RD,
	input wire logic [15:0] MGMT_WDATA,
	output logic [15:0] MGMT_RDATA,
	input wire logic PD_FAULT_EVT,
	input wire logic LP_AN_ABLE,
	input wire logic RX_PAGE_VALID,
	input wire logic RX_PAGE_BASE,
	input wire logic [15:0] RX_PAGE,
	input wire logic TX_NP_TAKEN,
	output logic TX_NP_PENDING,
	output logic [15:0] TX_NP_WORD,
	output logic NP_ENABLE
);
	typedef struct packed {
		logic pd_fault;
		logic page_rcvd;
		logic lp_able;
		logic lp_np;
		logic adv_np;
		logic np_more;
		logic np_msg;
		logic np_ack2;
		logic np_toggle;
		logic [10:0] np_code;
		logic np_pending;
		logic [15:0] lp_page;
		logic [15:0] rdata;
		logic [15:0] tx_word;
	} anpr_state_t;

	anpr_state_t st;
	anpr_state_t next_st;

	function automatic logic [15:0] anpr_page(input logic more, input logic msg,
		input logic ack2, input logic tog, input logic [10:0] code);
		anpr_page = {more, 1'b0, msg, ack2, tog, code};
	endfunction : anpr_page

	logic rd_exp;
	logic wr_np;
	assign rd_exp = MGMT_RD && (MGMT_ADDR == ANPR_ADDR_EXP);
	assign wr_np = MGMT_WR && (MGMT_ADDR == ANPR_ADDR_NP_TX);

	always_comb begin
		next_st = st;
		// Set wins over the read clear so no event is lost
		if (rd_exp) begin
			next_st.pd_fault = 1'b0;
			next_st.page_rcvd = 1'b0;
		end
		if (PD_FAULT_EVT) begin
			next_st.pd_fault = 1'b1;
		end
		next_st.lp_able = LP_AN_ABLE;
		if (RX_PAGE_VALID) begin
			next_st.page_rcvd = 1'b1;
			if (RX_PAGE_BASE) begin
				next_st.lp_np = RX_PAGE[ANPR_BIT_NP];
			end else begin
				next_st.lp_page = RX_PAGE & ANPR_MASK_PAGE;
			end
		end
		if (MGMT_WR && (MGMT_ADDR == ANPR_ADDR_ADVERT)) begin
			next_st.adv_np = MGMT_WDATA[ANPR_BIT_NP];
		end
		if (wr_np) begin
			// Toggle is not writable; arbitration alone owns it
			next_st.np_more = MGMT_WDATA[ANPR_BIT_NP];
			next_st.np_msg = MGMT_WDATA[ANPR_BIT_MSG];
			next_st.np_ack2 = MGMT_WDATA[ANPR_BIT_ACK2];
			next_st.np_code = MGMT_WDATA[ANPR_CODE_W-1:0];
			next_st.np_pending = 1'b1;
		end
		if (TX_NP_TAKEN) begin
			// A write in the same cycle stays pending for the next page
			next_st.np_pending = wr_np;
			next_st.np_toggle = ~st.np_toggle;
		end
		next_st.tx_word = anpr_page(next_st.np_more, next_st.np_msg, next_st.np_ack2,
			next_st.np_toggle, next_st.np_code);
		next_st.rdata = 16'h0000;
		if (MGMT_RD) begin
			unique case (MGMT_ADDR)
				ANPR_ADDR_ADVERT: next_st.rdata = {st.adv_np, 15'h0000};
				ANPR_ADDR_EXP: next_st.rdata = {ANPR_RST_EXP_RSVD, st.pd_fault,
					st.lp_np, 1'b1, st.page_rcvd, st.lp_able};
				ANPR_ADDR_NP_TX: next_st.rdata = st.tx_word;
				ANPR_ADDR_NP_RX: next_st.rdata = st.lp_page;
				default: next_st.rdata = 16'h0000;
			endcase
		end
	end

	always_ff @(posedge CLK) begin
		if (!RSTN) begin
			st.pd_fault <= 1'b0;
			st.page_rcvd <= 1'b0;
			st.lp_able <= 1'b0;
			st.lp_np <= 1'b0;
			st.adv_np <= ANPR_RST_ADV_NP;
			st.np_more <= ANPR_RST_NP_MORE;
			st.np_msg <= ANPR_RST_NP_MSG;
			st.np_ack2 <= ANPR_RST_NP_ACK2;
			st.np_toggle <= ANPR_RST_NP_TOGGLE;
			st.np_code <= ANPR_RST_NP_CODE;
			st.np_pending <= 1'b0;
			st.lp_page <= ANPR_RST_LP_PAGE;
			st.rdata <= 16'h0000;
			st.tx_word <= {ANPR_RST_NP_MORE, 1'b0, ANPR_RST_NP_MSG, ANPR_RST_NP_ACK2,
				ANPR_RST_NP_TOGGLE, ANPR_RST_NP_CODE};
		end else begin
			st <= next_st;
		end
	end

	assign MGMT_RDATA = st.rdata;
	assign TX_NP_PENDING = st.np_pending;
	assign TX_NP_WORD = st.tx_word;
	assign NP_ENABLE = st.adv_np;

	default clocking anpr_cb @(posedge CLK);
	endclocking
	default disable iff (!RSTN);

	a_pd_fault_set: assert property (PD_FAULT_EVT |=> st.pd_fault)
		else $error("fault event not latched");
	a_pd_fault_clear: assert property (rd_exp && !PD_FAULT_EVT |=> !st.pd_fault)
		else $error("fault bit not cleared by read");
	a_exp_read_bits: assert property (rd_exp |=> MGMT_RDATA[2]
		&& MGMT_RDATA[3] == $past(st.lp_np) && MGMT_RDATA[15:5] == 11'h000)
		else $error("expansion read value wrong");
	a_page_set: assert property (RX_PAGE_VALID |=> st.page_rcvd)
		else $error("page received not latched");
	a_page_hold: assert property (st.page_rcvd && !rd_exp |=> st.page_rcvd)
		else $error("page received dropped early");
	a_lp_able_track: assert property (!LP_AN_ABLE |=> !st.lp_able)
		else $error("partner able shown without cause");
	a_toggle_flip: assert property (TX_NP_TAKEN |=> st.np_toggle != $past(st.np_toggle))
		else $error("toggle did not alternate");
	a_toggle_hold: assert property (!TX_NP_TAKEN |=> $stable(st.np_toggle))
		else $error("toggle changed without a page");
	a_lp_capture: assert property (RX_PAGE_VALID && !RX_PAGE_BASE
		|=> st.lp_page == ($past(RX_PAGE) & ANPR_MASK_PAGE))
		else $error("partner page not captured");
	a_np_pending: assert property (wr_np |=> TX_NP_PENDING ##0
		TX_NP_WORD[10:0] == $past(MGMT_WDATA[10:0]))
		else $error("written page not offered");
	a_adv_np: assert property (MGMT_WR && MGMT_ADDR == ANPR_ADDR_ADVERT
		|=> NP_ENABLE == $past(MGMT_WDATA[15]))
		else $error("next page enable not stored");

	// Read data is a one-cycle answer; idle cycles must show zero
	a_rdata_idle: assert property (!MGMT_RD
		|=> MGMT_RDATA == 16'h0000)
		else $error("read data not idle zero");

	a_exp_rsvd: assert property (rd_exp
		|=> MGMT_RDATA[15:5] == ANPR_RST_EXP_RSVD)
		else $error("expansion reserved bits not zero");

	a_exp_np_able: assert property (rd_exp
		|=> MGMT_RDATA[ANPR_BIT_NP_ABLE])
		else $error("next page able bit not one");

	a_exp_fault_bit: assert property (rd_exp
		|=> MGMT_RDATA[ANPR_BIT_PD_FAULT] == $past(st.pd_fault))
		else $error("fault bit read wrong");

	a_exp_page_bit: assert property (rd_exp
		|=> MGMT_RDATA[ANPR_BIT_PAGE_RX] == $past(st.page_rcvd))
		else $error("page received bit read wrong");

	a_exp_lp_able: assert property (rd_exp
		|=> MGMT_RDATA[ANPR_BIT_LP_AN_ABLE] == $past(st.lp_able))
		else $error("partner able bit read wrong");

	a_lp_able_set: assert property (LP_AN_ABLE
		|=> st.lp_able)
		else $error("partner able not shown");

	a_page_clear: assert property (rd_exp && !RX_PAGE_VALID
		|=> !st.page_rcvd)
		else $error("page received not cleared by read");

	a_fault_hold: assert property (st.pd_fault && !rd_exp
		|=> st.pd_fault)
		else $error("fault bit dropped early");

	a_fault_rise: assert property ($rose(st.pd_fault)
		|-> $past(PD_FAULT_EVT))
		else $error("fault bit set without event");

	a_page_rise: assert property ($rose(st.page_rcvd)
		|-> $past(RX_PAGE_VALID))
		else $error("page received set without page");

	// Set must win over the read clear, or an event is lost
	a_fault_read_set: assert property (rd_exp && PD_FAULT_EVT
		|=> st.pd_fault)
		else $error("fault event lost to read clear");

	a_page_read_set: assert property (rd_exp && RX_PAGE_VALID
		|=> st.page_rcvd)
		else $error("page event lost to read clear");

	a_lp_np_base: assert property (RX_PAGE_VALID && RX_PAGE_BASE
		|=> st.lp_np == $past(RX_PAGE[ANPR_BIT_NP]))
		else $error("partner next page ability not stored");

	a_lp_np_hold: assert property (!(RX_PAGE_VALID && RX_PAGE_BASE)
		|=> $stable(st.lp_np))
		else $error("partner next page ability changed");

	a_lp_page_hold: assert property (!(RX_PAGE_VALID && !RX_PAGE_BASE)
		|=> $stable(st.lp_page))
		else $error("partner page changed without page");

	a_lp_page_code: assert property (RX_PAGE_VALID && !RX_PAGE_BASE
		|=> st.lp_page[10:0] == $past(RX_PAGE[10:0]))
		else $error("partner code field not captured");

	a_lp_page_ack: assert property (st.lp_page[ANPR_BIT_ACK] == 1'b0)
		else $error("partner page reserved bit set");

	a_no_write_rx: assert property (MGMT_WR && MGMT_ADDR == ANPR_ADDR_NP_RX
		&& !RX_PAGE_VALID |=> $stable(st.lp_page))
		else $error("partner page written by software");

	a_np_rx_read: assert property (MGMT_RD && MGMT_ADDR == ANPR_ADDR_NP_RX
		|=> MGMT_RDATA == $past(st.lp_page))
		else $error("partner page read wrong");

	a_np_rx_rsvd: assert property (MGMT_RD && MGMT_ADDR == ANPR_ADDR_NP_RX
		|=> MGMT_RDATA[ANPR_BIT_ACK] == 1'b0)
		else $error("partner page read reserved bit set");

	a_np_tx_read: assert property (MGMT_RD && MGMT_ADDR == ANPR_ADDR_NP_TX
		|=> MGMT_RDATA == $past(TX_NP_WORD))
		else $error("local page read wrong");

	a_np_tx_rsvd: assert property (MGMT_RD && MGMT_ADDR == ANPR_ADDR_NP_TX
		|=> MGMT_RDATA[ANPR_BIT_ACK] == 1'b0)
		else $error("local page read reserved bit set");

	a_adv_read: assert property (MGMT_RD && MGMT_ADDR == ANPR_ADDR_ADVERT
		|=> MGMT_RDATA == {$past(NP_ENABLE), 15'h0000})
		else $error("advertisement read wrong");

	a_adv_rsvd: assert property (MGMT_RD && MGMT_ADDR == ANPR_ADDR_ADVERT
		|=> MGMT_RDATA[14:0] == 15'h0000)
		else $error("advertisement low bits not zero");

	a_rdata_unmapped: assert property (MGMT_RD && MGMT_ADDR > ANPR_ADDR_NP_RX
		|=> MGMT_RDATA == 16'h0000)
		else $error("unmapped read not zero");

	a_word_rsvd: assert property (TX_NP_WORD[ANPR_BIT_ACK] == 1'b0)
		else $error("local page reserved bit set");

	a_word_toggle: assert property (TX_NP_WORD[ANPR_BIT_TOGGLE] == st.np_toggle)
		else $error("local page toggle mismatch");

	a_word_more: assert property (wr_np
		|=> TX_NP_WORD[ANPR_BIT_NP] == $past(MGMT_WDATA[ANPR_BIT_NP]))
		else $error("more pages flag not stored");

	a_word_msg: assert property (wr_np
		|=> TX_NP_WORD[ANPR_BIT_MSG] == $past(MGMT_WDATA[ANPR_BIT_MSG]))
		else $error("message flag not stored");

	a_word_ack2: assert property (wr_np
		|=> TX_NP_WORD[ANPR_BIT_ACK2] == $past(MGMT_WDATA[ANPR_BIT_ACK2]))
		else $error("comply flag not stored");

	a_word_hold: assert property (!wr_np && !TX_NP_TAKEN
		|=> $stable(TX_NP_WORD))
		else $error("local page changed without cause");

	a_code_hold: assert property (!wr_np
		|=> $stable(TX_NP_WORD[10:0]))
		else $error("code field changed without write");

	a_flags_hold: assert property (!wr_np
		|=> $stable(TX_NP_WORD[15:12]))
		else $error("page flags changed without write");

	a_toggle_word: assert property (TX_NP_TAKEN
		|=> TX_NP_WORD[ANPR_BIT_TOGGLE] != $past(TX_NP_WORD[ANPR_BIT_TOGGLE]))
		else $error("offered toggle did not alternate");

	a_pend_clear: assert property (TX_NP_TAKEN && !wr_np
		|=> !TX_NP_PENDING)
		else $error("pending not cleared when sent");

	// A write racing the send queues the new page rather than losing it
	a_pend_requeue: assert property (TX_NP_TAKEN && wr_np
		|=> TX_NP_PENDING)
		else $error("page written during send lost");

	a_pend_hold: assert property (TX_NP_PENDING && !TX_NP_TAKEN
		|=> TX_NP_PENDING)
		else $error("pending dropped before send");

	a_pend_rise: assert property ($rose(TX_NP_PENDING)
		|-> $past(wr_np))
		else $error("pending set without write");

	a_np_en_hold: assert property (!(MGMT_WR && MGMT_ADDR == ANPR_ADDR_ADVERT)
		|=> $stable(NP_ENABLE))
		else $error("next page enable changed without write");
endmodule : anpr_regs
`default_nettype wire

// ---- anpr_pkg.sv ----
// Package for the auto-negotiation next page register bank.
// Assumes management addresses are 5-bit register numbers of one port.
`default_nettype none
package anpr_pkg;
	localparam logic [4:0] ANPR_ADDR_ADVERT = 5'h04;
	localparam logic [4:0] ANPR_ADDR_EXP = 5'h06;
	localparam logic [4:0] ANPR_ADDR_NP_TX = 5'h07;
	localparam logic [4:0] ANPR_ADDR_NP_RX = 5'h08;
	localparam int ANPR_BIT_NP = 15;
	localparam int ANPR_BIT_ACK = 14;
	localparam int ANPR_BIT_MSG = 13;
	localparam int ANPR_BIT_ACK2 = 12;
	localparam int ANPR_BIT_TOGGLE = 11;
	localparam int ANPR_BIT_PD_FAULT = 4;
	localparam int ANPR_BIT_LP_NP_ABLE = 3;
	localparam int ANPR_BIT_NP_ABLE = 2;
	localparam int ANPR_BIT_PAGE_RX = 1;
	localparam int ANPR_BIT_LP_AN_ABLE = 0;
	localparam int ANPR_CODE_W = 11;
	localparam logic ANPR_RST_NP_MORE = 1'h0;
	localparam logic ANPR_RST_NP_MSG = 1'h1;
	localparam logic ANPR_RST_NP_ACK2 = 1'h0;
	localparam logic ANPR_RST_NP_TOGGLE = 1'h0;
	localparam logic [10:0] ANPR_RST_NP_CODE = 11'h001;
	localparam logic ANPR_RST_ADV_NP = 1'h0;
	localparam logic [15:0] ANPR_RST_LP_PAGE = 16'h0000;
	localparam logic [10:0] ANPR_RST_EXP_RSVD = 11'h000;
	localparam logic [15:0] ANPR_MASK_PAGE = 16'hBFFF;
endpackage : anpr_pkg
`default_nettype wire

// ---- anpr_arb_model.sv ----
// Arbitration-side model: sends each pending local page, then answers.
// Assumes the register bank and this model share one clock.
`default_nettype none
module anpr_arb_model (
	input wire logic CLK,
	input wire logic TX_NP_PENDING,
	input wire logic [3:0] DLY,
	input wire logic [15:0] REPLY,
	output logic TX_NP_TAKEN,
	output logic RX_PAGE_VALID,
	output logic [15:0] RX_PAGE
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		TX_NP_TAKEN = 1'h0;
		RX_PAGE_VALID = 1'h0;
		RX_PAGE = 16'h0000;
		forever begin
			@(posedge CLK);
			// Idle word lines keep moving so a stale capture shows up
			#1 RX_PAGE = ~RX_PAGE;
			if (TX_NP_PENDING === 1'h1) begin
				repeat (DLY) @(posedge CLK);
				#1 TX_NP_TAKEN = 1'h1;
				@(posedge CLK);
				#1 TX_NP_TAKEN = 1'h0;
				RX_PAGE = REPLY;
				RX_PAGE_VALID = 1'h1;
				@(posedge CLK);
				#1 RX_PAGE_VALID = 1'h0;
			end
		end
	end
endmodule : anpr_arb_model
`default_nettype wire

// ---- autoneg_next_page_regs_tb.sv ----
// Self-checking bench for the next page register bank.
// Assumes the arbitration model answers every pending local page.
`default_nettype none
module autoneg_next_page_regs_tb;
	import anpr_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 0, rstn = 0, wr = 0, rd = 0, pd = 0, lpan = 0, base = 0;
	logic [4:0] addr = 5'h00;
	logic [15:0] wd = 16'h0000, rdata, word, page, reply = 16'h0000, w, r, lp = 16'h0000;
	logic pend, take, rxv, npe, tg = 0, lpnp = 0;
	logic [3:0] dly = 4'h1;
	int fail_count = 0, n_checks = 0, seed = 67685;
	anpr_regs u_dut (.CLK(clk), .RSTN(rstn), .MGMT_ADDR(addr), .MGMT_WR(wr), .MGMT_RD(rd),
		.MGMT_WDATA(wd), .MGMT_RDATA(rdata), .PD_FAULT_EVT(pd), .LP_AN_ABLE(lpan),
		.RX_PAGE_VALID(rxv), .RX_PAGE_BASE(base), .RX_PAGE(page), .TX_NP_TAKEN(take),
		.TX_NP_PENDING(pend), .TX_NP_WORD(word), .NP_ENABLE(npe));
	anpr_arb_model u_arb (.CLK(clk), .TX_NP_PENDING(pend), .DLY(dly), .REPLY(reply),
		.TX_NP_TAKEN(take), .RX_PAGE_VALID(rxv), .RX_PAGE(page));
	initial forever #5 clk = ~clk;
	function automatic logic [15:0] np(input logic [15:0] v);
		return {v[15], 1'h0, v[13:12], tg, v[10:0]};
	endfunction : np
	function automatic logic [15:0] es(input logic f, input logic p);
		return {11'h000, f, lpnp, 1'h1, p, lpan};
	endfunction : es
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("BAD %0t %h %h", $time, got, exp);
		end
	endtask : chk
	task automatic acc(input logic [4:0] a, input logic we, input logic [15:0] d);
		@(posedge clk);
		#1 {wr, rd} = {we, !we};
		addr = a;
		wd = d;
		@(posedge clk);
		#1 {wr, rd} = 2'h0;
	endtask : acc
	task automatic rdc(input logic [4:0] a, input logic [15:0] exp);
		acc(a, 1'h0, 16'h0000);
		chk(rdata, exp);
	endtask : rdc
	task automatic stop_test;
		if (fail_count == 0 && n_checks > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : stop_test
	initial begin
		#100000;
		fail_count++;
		stop_test;
	end
	initial begin
		repeat (3) @(posedge clk);
		#1 rstn = 1;
		rdc(ANPR_ADDR_EXP, 16'h0004);
		rdc(ANPR_ADDR_NP_TX, 16'h2001);
		rdc(ANPR_ADDR_NP_RX, 16'h0000);
		rdc(ANPR_ADDR_ADVERT, 16'h0000);
		rdc(5'h1F, 16'h0000);
		for (int i = 0; i < 12; i++) begin
			w = $random(seed);
			r = $random(seed);
			// First pass uses the all-ones code field boundary
			if (i == 0) w = 16'hFFFF;
			lpan = w[4];
			base = i[0];
			dly = r[3:0];
			reply = r;
			acc(ANPR_ADDR_NP_TX, 1'h1, w);
			chk(word, np(w));
			pd = r[5];
			repeat (60) if (pend === 1'h1) @(posedge clk);
			repeat (3) @(posedge clk);
			#1 pd = 1'h0;
			tg = ~tg;
			if (base) lpnp = r[15];
			else lp = r & ANPR_MASK_PAGE;
			chk({15'h0000, pend}, 16'h0000);
			rdc(ANPR_ADDR_NP_TX, np(w));
			rdc(ANPR_ADDR_NP_RX, lp);
			rdc(ANPR_ADDR_EXP, es(r[5], 1'h1));
			rdc(ANPR_ADDR_EXP, es(1'h0, 1'h0));
			acc(ANPR_ADDR_NP_RX, 1'h1, ~r);
			acc(ANPR_ADDR_ADVERT, 1'h1, w);
			rdc(ANPR_ADDR_NP_RX, lp);
			chk({15'h0000, npe}, {15'h0000, w[15]});
			rdc(ANPR_ADDR_ADVERT, {w[15], 15'h0000});
		end
		stop_test;
	end
endmodule : autoneg_next_page_regs_tb
`default_nettype wire
